// >>> hdl/ddi_pkg.sv
// Constants for the digital input function decoder.
// Assumes one control clock; codes arrive as plain 7-bit configuration.
package ddi_pkg;
  localparam int unsigned NUM_INPUTS = 5;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned FREQ_W = 16;
  // Function codes
  localparam logic [6:0] FN_NONE = 7'h00;
  localparam logic [6:0] FN_RUN_RIGHT = 7'h01;
  localparam logic [6:0] FN_RUN_LEFT = 7'h02;
  localparam logic [6:0] FN_REVERSE = 7'h03;
  localparam logic [6:0] FN_FIXED_1 = 7'h04;
  localparam logic [6:0] FN_FIXED_4 = 7'h07;
  localparam logic [6:0] FN_PSET_BIT0 = 7'h08;
  localparam logic [6:0] FN_RAMP_HOLD = 7'h09;
  localparam logic [6:0] FN_COAST = 7'h0a;
  localparam logic [6:0] FN_ESTOP = 7'h0b;
  localparam logic [6:0] FN_FAULT_ACK = 7'h0c;
  // Reset values of the input function selection
  localparam logic [34:0] FUNC_RESET = {7'h00, 7'h00, 7'h04, 7'h02, 7'h01};
  // Fault acknowledge configuration values
  localparam logic [1:0] ACK_CFG_NONE = 2'h0;
  localparam logic [1:0] ACK_CFG_ENABLE_LOW = 2'h1;
  // Drive mode encodings
  typedef enum logic [3:0]
  {
    DDI_IDLE = 4'h1,
    DDI_RUN = 4'h2,
    DDI_BLOCKED = 4'h4,
    DDI_FAULT = 4'h8
  } ddi_mode_t;
endpackage : ddi_pkg

// >>> hdl/ddi_core.sv
// Decoder of the functions assigned to the programmable control inputs.
// Assumes inputs synchronous to clock; fault cause comes from elsewhere.
// Operation
// - Code 01 rising edge with positive setpoint, no autostart: run right.
// - Code 02 rising edge with positive setpoint, no autostart: run left.
// - Autostart set: enable is level sensitive, held high by the outside.
// - Right and left enables together block the output.
// - In fault with cause gone and no code 12, enable falling edge clears the fault.
// - Code 03 high reverses the direction chosen by the enables.
// - Codes 04 to 07 high add fixed table entries one to four.
// - Several fixed frequencies sum with sign, plus minimum frequency.
// - Code 08 gives the low bit of the parameter set selection.
// - Code 09 low freezes the ramp, high lets it continue.
// - Code 10 low switches off the output voltage, coasting.
// - Code 11 low ramps down using the fast stop time.
// - Code 12 acknowledges a pending fault on a rising edge once the fault cause is gone.
// - Without code 12, a low enable acknowledges when so configured.
// - Code 00 has no effect at all.
// - Reset codes are 1, 2, 4 for inputs one to three, else zero.
`timescale 1ns/100ps
module ddi_core #(
  parameter int unsigned NUM_IN = ddi_pkg::NUM_INPUTS,
  parameter int unsigned FW = ddi_pkg::FREQ_W
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control input terminals
  input wire logic [NUM_IN-1:0] control_in,
  // Configuration
  input wire logic [NUM_IN*7-1:0] input_function_select,
  input wire logic func_load,
  input wire logic auto_start_on_power,
  input wire logic [1:0] fault_ack_config,
  input wire logic signed [4*FW-1:0] fixed_frequency_table,
  input wire logic signed [FW-1:0] minimum_frequency,
  input wire logic min_freq_add,
  input wire logic signed [FW-1:0] setpoint,
  // Fault status from the protection logic
  input wire logic fault_event,
  input wire logic fault_cause_active,
  // Drive commands
  output logic run_right,
  output logic run_left,
  output logic output_blocked,
  output logic voltage_off,
  output logic fast_stop,
  output logic ramp_hold,
  output logic param_set_bit0,
  output logic signed [FW-1:0] setpoint_out,
  output logic fault_flag,
  output logic [35:0] func_codes_q
);
  typedef struct packed
  {
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [NUM_IN-1:0] prev;
    logic [NUM_IN*7-1:0] func;
    logic [3:0] mode;
    logic right;
    logic left;
    logic blocked;
    logic coast;
    logic estop;
    logic hold;
    logic pset0;
    logic signed [FW-1:0] sp;
    logic fault;
  } ddi_state_t;

  ddi_state_t s_q;
  ddi_state_t s_d;

  // Decode one input's code, unknown codes give none
  function automatic logic [6:0] code_of(input logic [NUM_IN*7-1:0] f,
                                         input int unsigned i);
    logic [6:0] c;
    c = f[i*7 +: 7];
    if (c > ddi_pkg::FN_FAULT_ACK)
    begin
      c = ddi_pkg::FN_NONE;
    end
    return c;
  endfunction : code_of

  always_comb
  begin
    logic [6:0] c;
    logic en_r_lvl;
    logic en_l_lvl;
    logic en_r_rise;
    logic en_l_rise;
    logic en_fall;
    logic rev;
    logic coast_req;
    logic estop_req;
    logic hold_req;
    logic ack_present;
    logic ack_rise;
    logic go_r;
    logic go_l;
    logic signed [FW+2:0] sum;
    c = '0;
    en_r_lvl = 1'b0;
    en_l_lvl = 1'b0;
    en_r_rise = 1'b0;
    en_l_rise = 1'b0;
    en_fall = 1'b0;
    rev = 1'b0;
    coast_req = 1'b0;
    estop_req = 1'b0;
    hold_req = 1'b0;
    ack_present = 1'b0;
    ack_rise = 1'b0;
    go_r = 1'b0;
    go_l = 1'b0;
    sum = (FW+3)'(setpoint);
    s_d = s_q;
    s_d.sync1 = control_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    if (func_load)
    begin
      s_d.func = input_function_select;
    end
    for (int unsigned i = 0; i < NUM_IN; i++)
    begin
      c = code_of(s_q.func, i);
      unique case (c)
        ddi_pkg::FN_RUN_RIGHT:
        begin
          en_r_lvl = en_r_lvl | s_q.sync2[i];
          en_r_rise = en_r_rise | (s_q.sync2[i] & ~s_q.prev[i]);
          en_fall = en_fall | (~s_q.sync2[i] & s_q.prev[i]);
        end
        ddi_pkg::FN_RUN_LEFT:
        begin
          en_l_lvl = en_l_lvl | s_q.sync2[i];
          en_l_rise = en_l_rise | (s_q.sync2[i] & ~s_q.prev[i]);
          en_fall = en_fall | (~s_q.sync2[i] & s_q.prev[i]);
        end
        ddi_pkg::FN_REVERSE: rev = rev | s_q.sync2[i];
        ddi_pkg::FN_PSET_BIT0: s_d.pset0 = s_q.sync2[i];
        ddi_pkg::FN_RAMP_HOLD: hold_req = hold_req | ~s_q.sync2[i];
        ddi_pkg::FN_COAST: coast_req = coast_req | ~s_q.sync2[i];
        ddi_pkg::FN_ESTOP: estop_req = estop_req | ~s_q.sync2[i];
        ddi_pkg::FN_FAULT_ACK:
        begin
          ack_present = 1'b1;
          ack_rise = ack_rise | (s_q.sync2[i] & ~s_q.prev[i]);
        end
        ddi_pkg::FN_NONE: ;
        default:
        begin
          // Codes 04..07: fixed frequency table entries
          if (s_q.sync2[i])
          begin
            // Part-select is unsigned; keep the entry's sign
            sum = sum + (FW+3)'($signed(fixed_frequency_table[
              (c - ddi_pkg::FN_FIXED_1) * FW +: FW]));
          end
        end
      endcase
    end
    if (min_freq_add)
    begin
      sum = sum + (FW+3)'(minimum_frequency);
    end
    // Saturate instead of wrapping the signed sum
    if (sum > (FW+3)'(2**(FW-1)-1))
      s_d.sp = {1'b0, {(FW-1){1'b1}}};
    else if (sum < -(FW+3)'(2**(FW-1)))
      s_d.sp = {1'b1, {(FW-1){1'b0}}};
    else
      s_d.sp = sum[FW-1:0];
    // Start: edge or level depending on autostart
    if (auto_start_on_power)
    begin
      go_r = en_r_lvl;
      go_l = en_l_lvl;
    end
    else
    begin
      go_r = en_r_rise & (setpoint > 0);
      go_l = en_l_rise & (setpoint > 0);
    end
    s_d.hold = hold_req & ~coast_req & ~estop_req;
    s_d.coast = coast_req;
    s_d.estop = estop_req & ~coast_req;
    // Fault handling, set wins over acknowledge
    if (fault_event)
      s_d.fault = 1'b1;
    else if (s_q.fault && !fault_cause_active)
    begin
      if (ack_present && ack_rise)
        s_d.fault = 1'b0;
      else if (!ack_present && en_fall)
        s_d.fault = 1'b0;
      else if (!ack_present && fault_ack_config ==
               ddi_pkg::ACK_CFG_ENABLE_LOW && !en_r_lvl && !en_l_lvl)
        s_d.fault = 1'b0;
    end
    unique case (s_q.mode)
      ddi_pkg::DDI_IDLE,
      ddi_pkg::DDI_RUN:
      begin
        if (en_r_lvl && en_l_lvl)
          s_d.mode = ddi_pkg::DDI_BLOCKED;
        else if (go_r || go_l)
        begin
          s_d.mode = ddi_pkg::DDI_RUN;
          s_d.right = go_r ^ rev;
          s_d.left = go_l ^ rev;
        end
        else if (!en_r_lvl && !en_l_lvl)
          s_d.mode = ddi_pkg::DDI_IDLE;
        if (s_q.mode == ddi_pkg::DDI_RUN && s_d.mode == ddi_pkg::DDI_RUN)
        begin
          s_d.right = en_r_lvl ^ rev;
          s_d.left = en_l_lvl ^ rev;
        end
      end
      ddi_pkg::DDI_BLOCKED:
        if (!(en_r_lvl && en_l_lvl))
          s_d.mode = ddi_pkg::DDI_IDLE;
      ddi_pkg::DDI_FAULT:
        if (!s_q.fault)
          s_d.mode = ddi_pkg::DDI_IDLE;
      default: s_d.mode = ddi_pkg::DDI_IDLE;
    endcase
    if (s_q.fault)
      s_d.mode = ddi_pkg::DDI_FAULT;
    if (s_d.mode != ddi_pkg::DDI_RUN || coast_req || estop_req)
    begin
      // Stops dominate run commands
      s_d.right = 1'b0;
      s_d.left = 1'b0;
    end
    s_d.blocked = (s_d.mode == ddi_pkg::DDI_BLOCKED);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.func <= ddi_pkg::FUNC_RESET;
      s_q.mode <= ddi_pkg::DDI_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign run_right = s_q.right;
  assign run_left = s_q.left;
  assign output_blocked = s_q.blocked;
  assign voltage_off = s_q.coast;
  assign fast_stop = s_q.estop;
  assign ramp_hold = s_q.hold;
  assign param_set_bit0 = s_q.pset0;
  assign setpoint_out = s_q.sp;
  assign fault_flag = s_q.fault;
  assign func_codes_q = {1'b0, s_q.func};

  chk_both_block: assert property (@(posedge clock) disable iff (rst)
    s_q.mode == ddi_pkg::DDI_BLOCKED |-> !run_right && !run_left)
    else $error("run while both enables active");
  chk_coast_stop: assert property (@(posedge clock) disable iff (rst)
    voltage_off |-> !run_right && !run_left && !ramp_hold)
    else $error("coast did not override");
  chk_estop_run: assert property (@(posedge clock) disable iff (rst)
    fast_stop |-> !run_right && !run_left)
    else $error("run during emergency stop");
  chk_fault_set: assert property (@(posedge clock) disable iff (rst)
    fault_event |=> fault_flag)
    else $error("fault not raised");
  chk_fault_hold: assert property (@(posedge clock) disable iff (rst)
    fault_flag && fault_cause_active |=> fault_flag)
    else $error("fault cleared while cause active");
  chk_no_run_fault: assert property (@(posedge clock) disable iff (rst)
    fault_flag |=> !run_right && !run_left)
    else $error("run in fault");
  chk_dir_excl: assert property (@(posedge clock) disable iff (rst)
    !(run_right && run_left))
    else $error("both directions driven");
  chk_sync_delay: assert property (@(posedge clock) disable iff (rst)
    $rose(control_in[0]) ##1 control_in[0] |=> $rose(s_q.sync2[0]))
    else $error("input sync latency wrong");
endmodule : ddi_core

// >>> testbench/ddi_terminals.sv
// Model of the switch contacts on the control input terminals.
// Assumes the bench sets the wanted levels just after a rising edge.
`timescale 1ns/100ps
module ddi_terminals #(
  parameter int unsigned N = 5
)
(
  // Clock
  input wire logic clock,
  // Wanted contact levels
  input wire logic [N-1:0] want,
  // Terminal levels
  output logic [N-1:0] level
);
  // Contacts only move at an edge; a held level keeps autostart alive
  always @(posedge clock)
  begin
    level <= want;
  end
endmodule : ddi_terminals

// >>> testbench/drive_digital_input_functions_tb.sv
// Self-checking bench of the control input function decoder.
// Assumes the terminal model and the decoder; one 40 MHz clock.
`timescale 1ns/100ps
module drive_digital_input_functions_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] want = '0;
  logic [4:0] control_in;
  logic [34:0] sel = '0;
  logic func_load = 1'b0;
  logic auto_start = 1'b0;
  logic [1:0] ack_cfg = 2'h0;
  logic [63:0] tbl = {16'h0100, 16'hfff8, 16'h0020, 16'h0010};
  logic signed [15:0] setpoint = 16'sh0200;
  logic min_add = 1'b0;
  logic fault_event = 1'b0;
  logic cause = 1'b0;
  logic run_right, run_left, output_blocked, voltage_off, fast_stop;
  logic ramp_hold, param_set_bit0, fault_flag;
  logic signed [15:0] setpoint_out;
  logic [35:0] func_codes_q;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  ddi_terminals u_ddi_terminals (.clock(clock), .want(want),
    .level(control_in));
  ddi_core u_ddi_core (.clock(clock), .rst(rst), .control_in(control_in),
    .input_function_select(sel), .func_load(func_load),
    .auto_start_on_power(auto_start), .fault_ack_config(ack_cfg),
    .fixed_frequency_table(tbl), .minimum_frequency(16'sh0005),
    .min_freq_add(min_add), .setpoint(setpoint),
    .fault_event(fault_event), .fault_cause_active(cause),
    .run_right(run_right), .run_left(run_left),
    .output_blocked(output_blocked), .voltage_off(voltage_off),
    .fast_stop(fast_stop), .ramp_hold(ramp_hold),
    .param_set_bit0(param_set_bit0), .setpoint_out(setpoint_out),
    .fault_flag(fault_flag), .func_codes_q(func_codes_q));
  task chk(input string what, input logic [35:0] seen,
    input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Terminal change needs one edge in the model and three in the core
  task put(input logic [4:0] v);
    @(posedge clock);
    want <= v;
    repeat (5) @(posedge clock);
    #1;
  endtask : put
  task load(input logic [34:0] c);
    @(posedge clock);
    sel <= c;
    func_load <= 1'b1;
    @(posedge clock);
    func_load <= 1'b0;
  endtask : load
  task fault_hit;
    @(posedge clock);
    fault_event <= 1'b1;
    cause <= 1'b1;
    @(posedge clock);
    fault_event <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("fault_flag", fault_flag, 1);
  endtask : fault_hit
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // Whole run is under two hundred cycles; the ceiling leaves wide margin
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("codes", func_codes_q, {1'b0, ddi_pkg::FUNC_RESET});
    chk("run_right", run_right, 0);
    $display("test reset done");
    put(5'b00001);
    chk("run_right", run_right, 1);
    chk("run_left", run_left, 0);
    put(5'b00011);
    chk("output_blocked", output_blocked, 1);
    chk("run_right", run_right, 0);
    put(5'b00100);
    chk("setpoint_out", setpoint_out, 16'sh0210);
    put(5'b00010);
    chk("run_left", run_left, 1);
    chk("run_right", run_right, 0);
    $display("test defaults done");
    load({7'h07, 7'h06, 7'h05, 7'h03, 7'h01});
    min_add <= 1'b1;
    put(5'b00010);
    put(5'b00011);
    chk("run_left", run_left, 1);
    chk("run_right", run_right, 0);
    put(5'b11111);
    chk("setpoint_out", setpoint_out, 16'sh031d);
    @(posedge clock);
    min_add <= 1'b0;
    $display("test reverse and sum done");
    load({7'h00, 7'h0b, 7'h0a, 7'h09, 7'h08});
    put(5'b01101);
    chk("param_set_bit0", param_set_bit0, 1);
    chk("ramp_hold", ramp_hold, 1);
    put(5'b00101);
    chk("fast_stop", fast_stop, 1);
    chk("ramp_hold", ramp_hold, 0);
    put(5'b00001);
    chk("voltage_off", voltage_off, 1);
    put(5'b10001);
    chk("voltage_off", voltage_off, 1);
    chk("param_set_bit0", param_set_bit0, 1);
    $display("test stops done");
    load({7'h0d, 7'h0d, 7'h0d, 7'h0c, 7'h01});
    put(5'b00000);
    fault_hit();
    put(5'b00010);
    chk("fault_flag", fault_flag, 1);
    put(5'b00000);
    @(posedge clock);
    cause <= 1'b0;
    put(5'b00010);
    chk("fault_flag", fault_flag, 0);
    put(5'b11100);
    chk("run_right", run_right, 0);
    chk("setpoint_out", setpoint_out, 16'sh0200);
    $display("test acknowledge input done");
    load(ddi_pkg::FUNC_RESET);
    put(5'b00001);
    fault_hit();
    @(posedge clock);
    cause <= 1'b0;
    put(5'b00000);
    chk("fault_flag", fault_flag, 0);
    fault_hit();
    @(posedge clock);
    cause <= 1'b0;
    put(5'b00000);
    chk("fault_flag", fault_flag, 1);
    @(posedge clock);
    ack_cfg <= ddi_pkg::ACK_CFG_ENABLE_LOW;
    repeat (2) @(posedge clock);
    #1;
    chk("fault_flag", fault_flag, 0);
    $display("test enable acknowledge done");
    @(posedge clock);
    setpoint <= 16'sh0000;
    put(5'b00001);
    chk("run_right", run_right, 0);
    @(posedge clock);
    setpoint <= 16'sh0200;
    auto_start <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    chk("run_right", run_right, 1);
    $display("test autostart done");
    wrap_up();
  end
endmodule : drive_digital_input_functions_tb
